// ---- msas_pkg.sv ----
// Constants for the monitor alert status and mask block.
// Assumes the includer imports the whole package into its module header.
package msas_pkg;

   // Register offsets on the device register port
   localparam logic [7:0] MSAS_OFS_STATUS_ONE = 8'h41; // Summary plus limit flags
   localparam logic [7:0] MSAS_OFS_STATUS_TWO = 8'h42; // fault_status_two
   localparam logic [7:0] MSAS_OFS_MASK_ONE   = 8'h74; // alert_mask_one
   localparam logic [7:0] MSAS_OFS_MASK_TWO   = 8'h75; // alert_mask_two

   // First status / first mask field positions
   localparam int MSAS_B1_SUMMARY     = 7; // second_register_summary
   localparam int MSAS_B1_REMOTE_TWO  = 6; // remote_two_temp_flag
   localparam int MSAS_B1_LOCAL       = 5; // local_temp_flag
   localparam int MSAS_B1_REMOTE_ONE  = 4; // remote_one_temp_flag
   localparam int MSAS_B1_MAIN_SUPPLY = 2; // Main supply flag
   localparam int MSAS_B1_CORE_SUPPLY = 1; // core_supply_flag

   // Second status / second mask field positions
   localparam int MSAS_B2_DIODE_TWO   = 7; // diode_two_fault
   localparam int MSAS_B2_DIODE_ONE   = 6; // diode_one_fault
   localparam int MSAS_B2_FAN_FOUR    = 5; // fan_four_or_timer_flag
   localparam int MSAS_B2_FAN_THREE   = 4; // fan_three_slow
   localparam int MSAS_B2_FAN_TWO     = 3; // fan_two_slow
   localparam int MSAS_B2_FAN_ONE     = 2; // fan_one_slow
   localparam int MSAS_B2_OVERTEMP    = 1; // overtemperature_flag
   localparam int MSAS_B2_LATCH       = 0; // remote_two_latch_flag

   // Implemented bits of each register; the rest read as zero
   localparam logic [7:0] MSAS_STAT1_USED = 8'h76; // Bits 6,5,4,2,1 from sources
   localparam logic [7:0] MSAS_MASK1_USED = 8'hF6; // Bit 7 plus source masks
   localparam logic [7:0] MSAS_STAT2_USED = 8'hFF; // All eight bits carry flags
   localparam logic [7:0] MSAS_MASK2_USED = 8'hFE; // Bit 0 unused
   localparam logic [7:0] MSAS_STAT2_STICKY = 8'hFD; // All but overtemperature

   // Reset values
   localparam logic [7:0] MSAS_MASK1_RST = 8'h00; // Nothing masked
   localparam logic [7:0] MSAS_MASK2_RST = 8'h00; // Nothing masked
   localparam logic [7:0] MSAS_ZERO8     = 8'h00; // Cleared byte

endpackage : msas_pkg

// ---- msas_flag_bank.sv ----
// Eight status flags, each sticky, following its source level, or held at zero if unused.
// Assumes fault levels arrive on mclk and the clear strobe is one cycle wide.
`timescale 1ns/1ns
`default_nettype none

module msas_flag_bank
   import msas_pkg::*;
#(
   parameter logic [7:0] USED   = 8'hFF, // Bits that carry a flag
   parameter logic [7:0] STICKY = 8'hFF  // Bits that hold until read
) (
   input  wire logic       mclk,    // Device clock
   input  wire logic       rstn,    // Async reset, active low
   input  wire logic [7:0] fault,   // Live out-of-limit levels
   input  wire logic       rd_clr,  // Register read strobe
   output var  logic [7:0] flags_q  // Flag state
);

   logic [7:0] flags_d; // Next flag state

   // One slice per flag; a fault still present always wins over the read
   for (genvar k = 0; k < 8; k++) begin : g_flag
      always_comb begin
         if (!USED[k]) begin
            flags_d[k] = 1'b0;                      // Unused position
         end else if (STICKY[k]) begin
            flags_d[k] = fault[k] | (flags_q[k] & ~rd_clr);
         end else begin
            flags_d[k] = fault[k];
         end
      end
   end

   // Register only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= MSAS_ZERO8;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule : msas_flag_bank

`default_nettype wire

// ---- msas_alert_core.sv ----
// Sticky status capture, alert masks and the alert pin driver.
// Assumes limit comparators and the serial bus engine run on mclk,
// and that the bus engine gives one-cycle read and write strobes.
//
// What this block does
// - Diode open/short sets status two bits 7,6
// - Fan four slow or timer sets bit 5
// - Fans three, two, one set bits 4..2
// - Thermal overtemperature sets status two bit 1
// - Bit 0 reports remote two latch
// - Out-of-limit sets status bit immediately
// - Bit clears only after fault gone and read
// - Alert held while out of limit, until read
// - Overtemperature flag and its alert not sticky
// - Masks gate alert only, never status
// - Mask one bits block listed alert sources
// - Mask one bit 7 gates fully-masked second register
// - Mask two bits block diode, fan, overtemperature alerts
// - Mask two bit 5 blocks fan four/timer
// - Alert disabled until pin function enabled
// - Status one bit 7 summarises status two
// - Status one bits flag limit violations
// - Status holds past the latest comparison until read clears
`timescale 1ns/1ns
`default_nettype none

module msas_alert_core
   import msas_pkg::*;
(
   input  wire logic       mclk,                  // Device clock, 100 MHz
   input  wire logic       rstn,                  // Async reset, active low
   // Limit comparator levels, high while out of limit
   input  wire logic       remote_two_temp_fault, // Remote 2 temperature
   input  wire logic       local_temp_fault,      // Local temperature
   input  wire logic       remote_one_temp_fault, // Remote 1 temperature
   input  wire logic       main_supply_fault,     // Main supply
   input  wire logic       core_supply_fault,     // Processor-core supply
   input  wire logic       diode_two_fault,       // Diode 2 open or short
   input  wire logic       diode_one_fault,       // Diode 1 open or short
   input  wire logic       fan_four_slow,         // Fan 4 under speed
   input  wire logic       thermal_timer_over,    // Thermal timer past limit
   input  wire logic       thermal_timer_mode,    // Fourth tach pin is thermal input
   input  wire logic       fan_three_slow,        // Fan 3 under speed
   input  wire logic       fan_two_slow,          // Fan 2 under speed
   input  wire logic       fan_one_slow,          // Fan 1 under speed
   input  wire logic       overtemp_fault,        // Thermal pin limit exceeded
   input  wire logic       remote_two_latch,      // Remote 2 latch condition
   input  wire logic       alert_pin_enable,      // Pin set to alert function
   // Register port from the serial bus engine
   input  wire logic [7:0] reg_addr,              // Register offset
   input  wire logic       reg_wr,                // Write strobe
   input  wire logic [7:0] reg_wdata,             // Write data
   input  wire logic       reg_rd,                // Read strobe
   output var  logic [7:0] reg_rdata_q,           // Read data, next cycle
   // Open-drain alert pin
   output var  logic       alert_n_q,             // Alert level, active low
   output var  logic       alert_oe_q             // High while pulling pin low
);

   // Assembled live fault vectors
   logic [7:0] fault_one;     // Sources of status one
   logic [7:0] fault_two;     // Sources of status two
   logic       fan_four_src;  // Shared bit 5 source

   // Status flags
   logic [7:0] stat1_q;       // Status one flags, summary excluded
   logic [7:0] stat2_q;       // fault_status_two
   logic [7:0] stat1_view;    // Status one as software sees it

   // Masks
   logic [7:0] mask1_q;       // alert_mask_one
   logic [7:0] mask1_d;       // Next alert_mask_one
   logic [7:0] mask2_q;       // alert_mask_two
   logic [7:0] mask2_d;       // Next alert_mask_two

   // Decoded accesses
   logic       rd_one;        // Read of status one
   logic       rd_two;        // Read of status two
   logic [7:0] rdata_d;       // Next read data

   // Alert terms
   logic [7:0] pend1;         // Unmasked pending status one
   logic [7:0] pend2;         // Unmasked pending status two
   logic       summary_alert; // Fully masked second register path
   logic       alert_any;     // Any reason to alert
   logic       alert_n_d;     // Next alert level
   logic       alert_oe_d;    // Next pin enable

   // Source routing; bit 5 source follows the fourth tach pin function
   always_comb begin
      fan_four_src = thermal_timer_mode ? thermal_timer_over : fan_four_slow;
      fault_one                      = MSAS_ZERO8;
      fault_one[MSAS_B1_REMOTE_TWO]  = remote_two_temp_fault;
      fault_one[MSAS_B1_LOCAL]       = local_temp_fault;
      fault_one[MSAS_B1_REMOTE_ONE]  = remote_one_temp_fault;
      fault_one[MSAS_B1_MAIN_SUPPLY] = main_supply_fault;
      fault_one[MSAS_B1_CORE_SUPPLY] = core_supply_fault;
      fault_two[MSAS_B2_DIODE_TWO]   = diode_two_fault;
      fault_two[MSAS_B2_DIODE_ONE]   = diode_one_fault;
      fault_two[MSAS_B2_FAN_FOUR]    = fan_four_src;
      fault_two[MSAS_B2_FAN_THREE]   = fan_three_slow;
      fault_two[MSAS_B2_FAN_TWO]     = fan_two_slow;
      fault_two[MSAS_B2_FAN_ONE]     = fan_one_slow;
      fault_two[MSAS_B2_OVERTEMP]    = overtemp_fault;
      fault_two[MSAS_B2_LATCH]       = remote_two_latch;
   end

   // Read decode; a read clears only what it returned
   assign rd_one = reg_rd && (reg_addr == MSAS_OFS_STATUS_ONE);
   assign rd_two = reg_rd && (reg_addr == MSAS_OFS_STATUS_TWO);

   // Status one bank, all sticky
   msas_flag_bank #(
      .USED   (MSAS_STAT1_USED),
      .STICKY (MSAS_STAT1_USED)
   ) u_stat_one (
      .mclk    (mclk),
      .rstn    (rstn),
      .fault   (fault_one),
      .rd_clr  (rd_one),
      .flags_q (stat1_q)
   );

   // Status two bank, overtemperature follows its level
   msas_flag_bank #(
      .USED   (MSAS_STAT2_USED),
      .STICKY (MSAS_STAT2_STICKY)
   ) u_stat_two (
      .mclk    (mclk),
      .rstn    (rstn),
      .fault   (fault_two),
      .rd_clr  (rd_two),
      .flags_q (stat2_q)
   );

   // Summary bit is live, so it drops as soon as status two empties
   always_comb begin
      stat1_view                  = stat1_q;
      stat1_view[MSAS_B1_SUMMARY] = |stat2_q;
   end

   // Mask writes; unused bits are kept at zero so they read back as zero
   always_comb begin
      mask1_d = mask1_q;
      mask2_d = mask2_q;
      if (reg_wr && (reg_addr == MSAS_OFS_MASK_ONE)) begin
         mask1_d = reg_wdata & MSAS_MASK1_USED;
      end
      if (reg_wr && (reg_addr == MSAS_OFS_MASK_TWO)) begin
         mask2_d = reg_wdata & MSAS_MASK2_USED;
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      unique case (reg_addr)
         MSAS_OFS_STATUS_ONE: rdata_d = stat1_view;
         MSAS_OFS_STATUS_TWO: rdata_d = stat2_q;
         MSAS_OFS_MASK_ONE:   rdata_d = mask1_q;
         MSAS_OFS_MASK_TWO:   rdata_d = mask2_q;
         default:             rdata_d = MSAS_ZERO8;
      endcase
      if (!reg_rd) begin
         rdata_d = reg_rdata_q; // Hold last answer between reads
      end
   end

   // Alert decision; masks act here only, never on the flags
   always_comb begin
      pend1 = stat1_q & ~mask1_q & MSAS_STAT1_USED;
      pend2 = stat2_q & ~mask2_q & MSAS_MASK2_USED;
      // With every second-register source masked, mask one bit 7 decides
      summary_alert = (|stat2_q) && ((mask2_q & MSAS_MASK2_USED) == MSAS_MASK2_USED)
                      && !mask1_q[MSAS_B1_SUMMARY];
      alert_any  = (|pend1) || (|pend2) || summary_alert;
      // Pin stays released until software picks the alert function
      alert_oe_d = alert_pin_enable && alert_any;
      alert_n_d  = !alert_oe_d;
   end

   // Register stage for masks, read data and pin
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mask1_q     <= MSAS_MASK1_RST;
         mask2_q     <= MSAS_MASK2_RST;
         reg_rdata_q <= MSAS_ZERO8;
         alert_n_q   <= 1'b1;
         alert_oe_q  <= 1'b0;
      end else begin
         mask1_q     <= mask1_d;
         mask2_q     <= mask2_d;
         reg_rdata_q <= rdata_d;
         alert_n_q   <= alert_n_d;
         alert_oe_q  <= alert_oe_d;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // Flag capture from diode two, fan four or timer, fan one, overtemperature, latch, local and core supply
   a_diode_sets_flag: assert property (
      diode_two_fault |=> stat2_q[MSAS_B2_DIODE_TWO])
      else $error("diode two fault did not set its flag");

   a_fan_four_route: assert property (
      (thermal_timer_mode && thermal_timer_over) |=> stat2_q[MSAS_B2_FAN_FOUR])
      else $error("timer over limit did not set bit five");

   a_fan_four_fan: assert property (
      (!thermal_timer_mode && fan_four_slow) |=> stat2_q[MSAS_B2_FAN_FOUR])
      else $error("fan four slow did not set bit five");

   a_fan_one_flag: assert property (
      fan_one_slow |=> stat2_q[MSAS_B2_FAN_ONE])
      else $error("fan one slow did not set its flag");

   a_overtemp_follows: assert property (
      stat2_q[MSAS_B2_OVERTEMP] == $past(overtemp_fault))
      else $error("overtemperature flag not following its level");

   a_latch_flag: assert property (
      remote_two_latch |=> stat2_q[MSAS_B2_LATCH])
      else $error("latch condition did not set bit zero");

   a_local_flag: assert property (
      local_temp_fault |=> stat1_q[MSAS_B1_LOCAL])
      else $error("local limit fault did not set its flag");

   a_core_flag: assert property (
      core_supply_fault |=> stat1_q[MSAS_B1_CORE_SUPPLY])
      else $error("core supply fault did not set its flag");

   // Sticky hold and read clear; a fault still present outlives the read
   a_sticky_hold: assert property (
      (stat2_q[MSAS_B2_DIODE_ONE] && !rd_two) |=> stat2_q[MSAS_B2_DIODE_ONE])
      else $error("sticky flag dropped without a read");

   a_read_clears: assert property (
      (rd_two && !diode_one_fault) |=> !stat2_q[MSAS_B2_DIODE_ONE])
      else $error("read after fault end did not clear flag");

   a_read_data: assert property (
      rd_two |=> (reg_rdata_q == $past(stat2_q)))
      else $error("status two read returned wrong flags");

   a_summary_read: assert property (
      rd_one |=> reg_rdata_q[MSAS_B1_SUMMARY] == $past(|stat2_q))
      else $error("summary bit wrong on status one read");

   // Masks: writes, and their reach into the flags and the pin
   a_mask_write: assert property (
      (reg_wr && (reg_addr == MSAS_OFS_MASK_TWO))
      |=> (mask2_q == ($past(reg_wdata) & MSAS_MASK2_USED)))
      else $error("mask two write not taken as expected");

   a_mask_keeps_flag: assert property (
      (mask1_q[MSAS_B1_LOCAL] && local_temp_fault) |=> stat1_q[MSAS_B1_LOCAL])
      else $error("masked source failed to set its flag");

   a_summary_gate: assert property (
      ((mask2_q == MSAS_MASK2_USED) && mask1_q[MSAS_B1_SUMMARY] && (stat1_q == MSAS_ZERO8))
      |=> alert_n_q)
      else $error("fully masked second register still alerted");

   // Alert pin
   a_alert_disabled: assert property (
      !alert_pin_enable |=> (alert_n_q && !alert_oe_q))
      else $error("alert driven while pin function off");

   a_alert_unmasked: assert property (
      (alert_pin_enable && stat1_q[MSAS_B1_CORE_SUPPLY] && !mask1_q[MSAS_B1_CORE_SUPPLY])
      |=> !alert_n_q)
      else $error("unmasked pending source gave no alert");

   a_unmasked_fan: assert property (
      (alert_pin_enable && stat2_q[MSAS_B2_FAN_ONE] && !mask2_q[MSAS_B2_FAN_ONE])
      |=> !alert_n_q)
      else $error("unmasked fan flag gave no alert");

   a_alert_release: assert property (
      (!alert_any) |=> (alert_n_q && !alert_oe_q))
      else $error("alert held with nothing pending");

   // Last pending cause gone with the overtemperature level
   a_overtemp_release: assert property (
      ($fell(stat2_q[MSAS_B2_OVERTEMP]) && (stat2_q == MSAS_ZERO8) && (stat1_q == MSAS_ZERO8))
      |=> alert_n_q)
      else $error("alert held after overtemperature ended");

   // Open-drain enable only ever mirrors the pulled-low level
   a_pin_mirror: assert property (
      alert_oe_q == !alert_n_q)
      else $error("pin enable and alert level disagree");

   // Main scenarios
   c_alert_seen:       cover property (alert_pin_enable && alert_any ##1 !alert_n_q);
   c_read_clear:       cover property (
      stat2_q[MSAS_B2_FAN_TWO] && rd_two ##1 !stat2_q[MSAS_B2_FAN_TWO]);
   c_masked_flag:      cover property (
      mask2_q[MSAS_B2_FAN_ONE] && stat2_q[MSAS_B2_FAN_ONE] && alert_n_q);
   c_overtemp_release: cover property (stat2_q[MSAS_B2_OVERTEMP] ##1 !stat2_q[MSAS_B2_OVERTEMP]);

endmodule : msas_alert_core

`default_nettype wire

// ---- msas_host_model.sv ----
// Host model on the register port: byte reads, writes, alert handling.
// Assumes strobes are taken at a rising mclk edge and data lands with it.
`timescale 1ns/1ns
`default_nettype none

module msas_host_model (
   input  wire logic       mclk,        // Device clock
   input  wire logic [7:0] reg_rdata_q, // Read data
   output var  logic [7:0] reg_addr,    // Register offset
   output var  logic       reg_wr,      // Write strobe
   output var  logic [7:0] reg_wdata,   // Write data
   output var  logic       reg_rd       // Read strobe
);
   // Idle from time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // One read; an idle cycle follows so strobes never merge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge mclk);
      #1;
      d        = reg_rdata_q;
      reg_rd   = 1'b0;
      reg_addr = ~a; // Stale address must not matter
      @(posedge mclk);
      #1;
   endtask : rd

   // One write, data scrambled after release
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~v;
      @(posedge mclk);
      #1;
   endtask : wr

   // Handler: find the source, then mask it so the alert stops
   task automatic handle(input logic [7:0] sa, ma, m, output logic [7:0] s);
      rd(sa, s);
      wr(ma, m);
   endtask : handle

   // Poll: unmask once the source bit has cleared
   task automatic poll(input logic [7:0] sa, ma, bm, output logic [7:0] s);
      rd(sa, s);
      if ((s & bm) == 8'h00) wr(ma, 8'h00);
   endtask : poll
endmodule : msas_host_model
`default_nettype wire

// ---- msas_alert_core_tb_top.sv ----
// Bench for the alert status and mask block: sources, masks, alert pin.
// Assumes the host model owns the register port, the bench the levels.
`timescale 1ns/1ns
`default_nettype none

module msas_alert_core_tb_top
   import msas_pkg::*;
;
   logic       mclk, rstn;       // Clock, reset active low
   logic [4:0] f1;               // Status one sources
   logic [7:0] f2;               // Status two sources, bit order of register
   logic       tmr_over;         // Thermal timer past limit
   logic       tmr_mode;         // Fourth tach pin as thermal input
   logic       en;               // Alert pin function
   logic [7:0] addr, wdata, rdata;
   logic       wr, rd, alert_n, alert_oe;
   logic [7:0] s;                // Last byte read
   int         err_total, checked;

   msas_alert_core msas_alert_core_i (.mclk(mclk), .rstn(rstn),
      .remote_two_temp_fault(f1[4]), .local_temp_fault(f1[3]),
      .remote_one_temp_fault(f1[2]), .main_supply_fault(f1[1]),
      .core_supply_fault(f1[0]), .diode_two_fault(f2[7]), .diode_one_fault(f2[6]),
      .fan_four_slow(f2[5]), .thermal_timer_over(tmr_over),
      .thermal_timer_mode(tmr_mode), .fan_three_slow(f2[4]), .fan_two_slow(f2[3]),
      .fan_one_slow(f2[2]), .overtemp_fault(f2[1]), .remote_two_latch(f2[0]),
      .alert_pin_enable(en), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata_q(rdata), .alert_n_q(alert_n), .alert_oe_q(alert_oe));

   msas_host_model msas_host_model_i (.mclk(mclk), .reg_rdata_q(rdata),
      .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));

   // Free-running clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic chk1(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   // Pin level and its enable must agree
   task automatic alc(input logic e);
      chk1("alert_n", e, alert_n);
      chk1("alert_oe", ~e, alert_oe);
   endtask : alc

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
      msas_host_model_i.rd(a, s);
      chk8(nm, e, s);
   endtask : rdc

   // Reset values, refused writes, unmapped read
   task automatic t_reset();
      alc(1'b1);
      rdc(MSAS_OFS_MASK_ONE, MSAS_MASK1_RST, "mask_one");
      rdc(MSAS_OFS_MASK_TWO, MSAS_MASK2_RST, "mask_two");
      msas_host_model_i.wr(MSAS_OFS_STATUS_TWO, 8'hFF);
      rdc(MSAS_OFS_STATUS_TWO, 8'h00, "status_two_ro");
      rdc(8'h10, 8'h00, "unmapped");
   endtask : t_reset

   // Every source sets its own bit, sticky until read after it ends; overtemperature reads back zero
   task automatic t_bits();
      logic [7:0] b1 [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
      for (int i = 0; i < 8; i++) begin
         f2 = 8'h01 << i;
         cyc(1);
         f2 = 8'h00;
         cyc(2);
         rdc(MSAS_OFS_STATUS_TWO, (i == 1) ? 8'h00 : 8'h01 << i, "st2_bit");
         rdc(MSAS_OFS_STATUS_TWO, 8'h00, "st2_clr");
      end
      for (int j = 0; j < 5; j++) begin
         f1 = 5'h01 << j;
         cyc(1);
         f1 = 5'h00;
         cyc(2);
         rdc(MSAS_OFS_STATUS_ONE, b1[j], "st1_bit");
         rdc(MSAS_OFS_STATUS_ONE, 8'h00, "st1_clr");
      end
   endtask : t_bits

   // Alert held while out of limit and until the read
   task automatic t_sticky();
      f2[2] = 1'b1;
      cyc(3);
      alc(1'b0);
      rdc(MSAS_OFS_STATUS_TWO, 8'h04, "st2_live");
      rdc(MSAS_OFS_STATUS_ONE, 8'h80, "summary");
      f2[2] = 1'b0;
      cyc(3);
      alc(1'b0);
      rdc(MSAS_OFS_STATUS_TWO, 8'h04, "st2_held");
      cyc(1);
      alc(1'b1);
   endtask : t_sticky

   // Overtemperature alert drops with its cause, no read
   task automatic t_overtemp();
      f2[1] = 1'b1;
      cyc(3);
      alc(1'b0);
      f2[1] = 1'b0;
      cyc(3);
      alc(1'b1);
   endtask : t_overtemp

   // Masks gate the pin only; fully masked second register path
   task automatic t_mask();
      msas_host_model_i.wr(MSAS_OFS_MASK_TWO, 8'hFF);
      rdc(MSAS_OFS_MASK_TWO, 8'hFE, "mask_two_rw");
      msas_host_model_i.wr(MSAS_OFS_MASK_ONE, 8'hFF);
      rdc(MSAS_OFS_MASK_ONE, 8'hF6, "mask_one_rw");
      msas_host_model_i.wr(MSAS_OFS_MASK_ONE, 8'h00);
      f2[7] = 1'b1;
      cyc(3);
      alc(1'b0);
      msas_host_model_i.handle(MSAS_OFS_STATUS_TWO, MSAS_OFS_MASK_ONE, 8'h80, s);
      chk8("handled", 8'h80, s);
      cyc(1);
      alc(1'b1);
      f2[7] = 1'b0;
      rdc(MSAS_OFS_STATUS_TWO, 8'h80, "masked_held");
      msas_host_model_i.poll(MSAS_OFS_STATUS_TWO, MSAS_OFS_MASK_TWO, 8'h80, s);
      chk8("polled", 8'h00, s);
      rdc(MSAS_OFS_MASK_TWO, 8'h00, "unmasked");
      // Core supply and local temperature both masked
      msas_host_model_i.wr(MSAS_OFS_MASK_ONE, 8'h22);
      f1 = 5'h09;
      cyc(3);
      alc(1'b1);
      f1 = 5'h00;
      rdc(MSAS_OFS_STATUS_ONE, 8'h22, "st1_masked");
      rdc(MSAS_OFS_STATUS_ONE, 8'h00, "st1_clr2");
      msas_host_model_i.wr(MSAS_OFS_MASK_ONE, 8'h00);
      // Same source unmasked now drives the pin until read
      f1[0] = 1'b1;
      cyc(3);
      alc(1'b0);
      f1[0] = 1'b0;
      rdc(MSAS_OFS_STATUS_ONE, 8'h02, "st1_unmasked");
      alc(1'b1);
   endtask : t_mask

   // Timer mode: bit 5 follows the timer, its mask follows along
   task automatic t_timer();
      tmr_mode = 1'b1;
      f2[5]    = 1'b1;
      cyc(3);
      rdc(MSAS_OFS_STATUS_TWO, 8'h00, "fan_four_ignored");
      f2[5] = 1'b0;
      msas_host_model_i.wr(MSAS_OFS_MASK_TWO, 8'h20);
      tmr_over = 1'b1;
      cyc(3);
      alc(1'b1);
      tmr_over = 1'b0;
      rdc(MSAS_OFS_STATUS_TWO, 8'h20, "timer_flag");
      rdc(MSAS_OFS_STATUS_TWO, 8'h00, "timer_clr");
      msas_host_model_i.wr(MSAS_OFS_MASK_TWO, 8'h00);
      tmr_mode = 1'b0;
   endtask : t_timer

   // Pin function off keeps the alert released
   task automatic t_enable();
      en    = 1'b0;
      f2[3] = 1'b1;
      cyc(3);
      alc(1'b1);
      f2[3] = 1'b0;
      en    = 1'b1;
      cyc(3);
      alc(1'b0);
      rdc(MSAS_OFS_STATUS_TWO, 8'h08, "st2_en");
      cyc(1);
      alc(1'b1);
   endtask : t_enable

   task automatic test_done();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      err_total = 0;
      checked   = 0;
      rstn      = 1'b0;
      f1        = 5'h00;
      f2        = 8'h00;
      tmr_over  = 1'b0;
      tmr_mode  = 1'b0;
      en        = 1'b0;
      cyc(4);
      rstn = 1'b1;
      cyc(1);
      t_reset();
      t_bits();
      en = 1'b1;
      t_sticky();
      t_overtemp();
      t_mask();
      t_timer();
      t_enable();
      test_done();
   end

   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #200000;
      err_total++;
      test_done();
   end
endmodule : msas_alert_core_tb_top
`default_nettype wire
